/* rtl/mbs_pkg.sv */
// Constants and types for the Modbus/TCP register server
package mbs_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ           = 10_000_000;
  localparam int IDLE_TIMEOUT_S   = 60;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;

  // ==========================================================
  // Sizes
  localparam int FRAME_DEPTH = 256;
  localparam int FIFO_DEPTH  = 16;

  // ==========================================================
  // Byte positions in a frame
  localparam logic [7:0] POS_PROTO_HI = 8'h02;
  localparam logic [7:0] POS_PROTO_LO = 8'h03;
  localparam logic [7:0] POS_LEN_HI   = 8'h04;
  localparam logic [7:0] POS_LEN_LO   = 8'h05;
  localparam logic [7:0] POS_UNIT     = 8'h06;
  localparam logic [7:0] POS_FN       = 8'h07;
  localparam logic [7:0] POS_ARG_HI   = 8'h08;
  localparam logic [7:0] POS_ARG_LO   = 8'h09;
  localparam logic [7:0] POS_CNT_HI   = 8'h0A;
  localparam logic [7:0] POS_CNT_LO   = 8'h0B;
  localparam logic [7:0] POS_BYTECNT  = 8'h0C;
  localparam logic [7:0] POS_WDATA    = 8'h0D;
  localparam logic [7:0] POS_RDATA    = 8'h09;
  localparam logic [7:0] LEN_BASE     = 8'h06;

  // ==========================================================
  // Function and error codes
  localparam logic [7:0] FN_RD_RELAY  = 8'h01;
  localparam logic [7:0] FN_RD_WORD   = 8'h03;
  localparam logic [7:0] FN_WR_RELAY  = 8'h05;
  localparam logic [7:0] FN_WR_WORD   = 8'h06;
  localparam logic [7:0] FN_LOOPBACK  = 8'h08;
  localparam logic [7:0] FN_WR_RELAYS = 8'h0F;
  localparam logic [7:0] FN_WR_WORDS  = 8'h10;
  localparam logic [7:0] EXC_FLAG     = 8'h80;
  localparam logic [7:0] ERR_FUNC     = 8'h01;
  localparam logic [7:0] ERR_ADDR     = 8'h02;

  // ==========================================================
  // Field values and limits
  localparam logic [7:0]  UNIT_LOCAL   = 8'h01;
  localparam logic [7:0]  UNIT_GW_MIN  = 8'h02;
  localparam logic [7:0]  UNIT_GW_MAX  = 8'h63;
  localparam logic [15:0] PROTO_MODBUS = 16'h0000;
  localparam logic [15:0] RELAY_MIN    = 16'h0FA1;
  localparam logic [15:0] RELAY_MAX    = 16'h1BA0;
  localparam logic [15:0] WORD_MIN     = 16'h0001;
  localparam logic [15:0] WORD_MAX     = 16'h1DB0;
  localparam logic [15:0] RD_RELAY_LIM = 16'h0100;
  localparam logic [15:0] RD_WORD_LIM  = 16'h0064;
  localparam logic [15:0] WR_RELAY_LIM = 16'h0100;
  localparam logic [15:0] WR_WORD_LIM  = 16'h0032;
  localparam logic [15:0] ONE_ITEM     = 16'h0001;
  localparam logic [15:0] RELAY_ON     = 16'hFF00;
  localparam logic [15:0] RELAY_OFF    = 16'h0000;
  localparam logic [15:0] LOOP_FIXED   = 16'h0000;
  localparam logic [15:0] LEN_FIXED    = 16'h0006;
  localparam logic [15:0] LEN_WR_HEAD  = 16'h0007;
  localparam logic [15:0] LEN_PDU_MIN  = 16'h0002;
  localparam logic [7:0]  LEN_ERR      = 8'h03;
  localparam logic [7:0]  LEN_RD_HEAD  = 8'h03;
  localparam logic [7:0]  LEN_ECHO     = 8'h06;

  // ==========================================================
  // Interpreter states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_RECV   = 3'h0,
    ST_CHECK  = 3'h1,
    ST_ACCESS = 3'h3,
    ST_BUILD  = 3'h2,
    ST_EMIT   = 3'h6
  } mbs_state_t;

endpackage : mbs_pkg

/* rtl/mbs_stream_if.sv */
// Byte stream carrier with last marker between server and FIFO
`timescale 1ns/1ps
interface mbs_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             last;
  logic             valid;
  logic             ready;
  modport src (output data, output last, output valid, input ready);
  modport snk (input data, input last, input valid, output ready);
endinterface : mbs_stream_if

/* rtl/mbs_fifo.sv */
// Response FIFO with valid and ready on both sides
`timescale 1ns/1ps
module mbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic   core_clk,
  input wire logic   rst_b,
  // Fill side
  mbs_stream_if.snk  wr,
  // Drain side
  mbs_stream_if.src  rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH:0] mem [DEPTH];
  logic [AW-1:0]  wr_ptr;
  logic [AW-1:0]  rd_ptr;
  logic [AW:0]    fill;
  logic           push;
  logic           pop;

  assign wr.ready = (fill != (AW+1)'(DEPTH));
  assign rd.valid = (fill != '0);
  assign rd.data  = mem[rd_ptr][WIDTH-1:0];
  assign rd.last  = mem[rd_ptr][WIDTH];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= {wr.last, wr.data};
    end
  end

  // ==========================================================
  // Pointers wrap explicitly so DEPTH need not be a power of two
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule : mbs_fifo

/* rtl/mbs_server.sv */
// Modbus/TCP request interpreter with response FIFO
`timescale 1ns/1ps

module mbs_server
  import mbs_pkg::*;
#(
  parameter int IDLE_CYC   = IDLE_TIMEOUT_CYC,
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst_b,
  // Connection
  input wire logic         conn_open,
  output logic             conn_close,
  // Request bytes
  input wire logic [7:0]   rx_data,
  input wire logic         rx_valid,
  output logic             rx_ready,
  // Response bytes
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             tx_valid,
  input wire logic         tx_ready,
  // Gateway hand-off
  output logic             gw_fwd,
  output logic [7:0]       gw_unit,
  // Relay and word store
  output logic             mem_req,
  output logic             mem_word,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input wire logic [15:0]  mem_rdata,
  input wire logic         mem_ack,
  input wire logic         mem_wr_ok
);

  // ==========================================================
  // Helpers
  function automatic logic range_ok(input logic [15:0] lo,
                                    input logic [15:0] hi,
                                    input logic [15:0] st,
                                    input logic [15:0] ct,
                                    input logic [15:0] lim);
    logic [16:0] top;
    top = {1'b0, st} + {1'b0, ct} - 17'h00001;
    return (ct != '0) && (ct <= lim) && (st >= lo) && (top <= {1'b0, hi});
  endfunction : range_ok

  function automatic logic [15:0] relay_bytes(input logic [15:0] ct);
    logic [16:0] sum;
    sum = {1'b0, ct} + 17'h00007;
    return sum[16:1] >> 2;
  endfunction : relay_bytes

  // ==========================================================
  // State
  mbs_state_t   state;
  logic [7:0]   frame [FRAME_DEPTH];
  logic [16:0]  rx_cnt;
  logic [16:0]  rx_total;
  logic [16:0]  next_total;
  logic         rx_fire;
  logic         rx_done;
  logic [7:0]   fn;
  logic [15:0]  nitems;
  logic [15:0]  idx;
  logic         is_write;
  logic         is_word;
  logic         err;
  logic [7:0]   err_code;
  logic [7:0]   tx_idx;
  logic [7:0]   tx_total;
  logic [31:0]  idle_cnt;
  logic         acc_fire;

  mbs_stream_if #(.WIDTH(8)) push_if ();
  mbs_stream_if #(.WIDTH(8)) pop_if ();

  // Request fields as stored
  logic [15:0]  f_proto;
  logic [7:0]   f_unit;
  logic [7:0]   f_fn;
  logic [15:0]  f_arg;
  logic [15:0]  f_cnt;
  logic [15:0]  f_plen;
  logic [15:0]  f_bc;

  assign f_proto = {frame[POS_PROTO_HI], frame[POS_PROTO_LO]};
  assign f_unit  = frame[POS_UNIT];
  assign f_fn    = frame[POS_FN];
  assign f_arg   = {frame[POS_ARG_HI], frame[POS_ARG_LO]};
  assign f_cnt   = {frame[POS_CNT_HI], frame[POS_CNT_LO]};
  assign f_plen  = rx_total[15:0] - {8'h00, LEN_BASE};
  assign f_bc    = {8'h00, frame[POS_BYTECNT]};

  // Write data for item i of the current request
  function automatic logic [15:0] item_data(input logic [7:0] f,
                                            input logic [15:0] i);
    logic [7:0] p;
    logic [7:0] b;
    p = '0;
    b = '0;
    item_data = '0;
    case (f)
      FN_WR_RELAY: item_data = {15'h0000, f_cnt == RELAY_ON};
      FN_WR_WORD:  item_data = f_cnt;
      FN_WR_RELAYS: begin
        p = POS_WDATA + {3'h0, i[7:3]};
        b = frame[p];
        item_data = {15'h0000, b[i[2:0]]};
      end
      FN_WR_WORDS: begin
        p = POS_WDATA + {i[6:0], 1'b0};
        item_data = {frame[p], frame[p + 8'h01]};
      end
      default: item_data = '0;
    endcase
  endfunction : item_data

  // ==========================================================
  // Receive: one frame at a time, nothing taken while busy
  assign rx_ready = (state == ST_RECV);
  assign rx_fire  = rx_valid && rx_ready;
  assign next_total = (rx_cnt == {9'h000, POS_LEN_LO})
                    ? {1'b0, frame[POS_LEN_HI], rx_data} + {9'h000, LEN_BASE}
                    : rx_total;
  assign rx_done  = rx_fire && (rx_cnt >= {9'h000, POS_LEN_LO})
                 && (rx_cnt + 17'h00001 == next_total);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_cnt   <= '0;
      rx_total <= '0;
    end else if (!conn_open || conn_close) begin
      rx_cnt <= '0;
    end else if (rx_fire) begin
      rx_total <= next_total;
      rx_cnt   <= rx_done ? '0 : rx_cnt + 17'h00001;
    end
  end

  // ==========================================================
  // Request check
  logic        chk_drop;
  logic        chk_gw;
  logic        chk_err;
  logic [7:0]  chk_code;
  logic [15:0] chk_items;
  logic        chk_wr;
  logic        chk_word;

  always_comb begin
    chk_gw    = (f_unit >= UNIT_GW_MIN) && (f_unit <= UNIT_GW_MAX);
    // Oversize frames were only partly stored, so they are dropped
    chk_drop  = (rx_total > 17'(FRAME_DEPTH))
             || (f_proto != PROTO_MODBUS)
             || (f_plen < LEN_PDU_MIN)
             || !((f_unit == UNIT_LOCAL) || chk_gw);
    chk_err   = 1'b0;
    chk_code  = ERR_ADDR;
    chk_items = '0;
    chk_wr    = 1'b0;
    chk_word  = 1'b0;
    case (f_fn)
      FN_RD_RELAY: begin
        chk_err   = (f_plen != LEN_FIXED)
                 || !range_ok(RELAY_MIN, RELAY_MAX, f_arg, f_cnt, RD_RELAY_LIM);
        chk_items = f_cnt;
      end
      FN_RD_WORD: begin
        chk_err   = (f_plen != LEN_FIXED)
                 || !range_ok(WORD_MIN, WORD_MAX, f_arg, f_cnt, RD_WORD_LIM);
        chk_items = f_cnt;
        chk_word  = 1'b1;
      end
      FN_WR_RELAY: begin
        chk_err   = (f_plen != LEN_FIXED)
                 || !range_ok(RELAY_MIN, RELAY_MAX, f_arg, ONE_ITEM, ONE_ITEM);
        chk_items = ((f_cnt == RELAY_ON) || (f_cnt == RELAY_OFF))
                  ? ONE_ITEM : '0;
        chk_wr    = 1'b1;
      end
      FN_WR_WORD: begin
        chk_err   = (f_plen != LEN_FIXED)
                 || !range_ok(WORD_MIN, WORD_MAX, f_arg, ONE_ITEM, ONE_ITEM);
        chk_items = ONE_ITEM;
        chk_wr    = 1'b1;
        chk_word  = 1'b1;
      end
      FN_LOOPBACK: begin
        chk_err = (f_plen != LEN_FIXED) || (f_arg != LOOP_FIXED);
      end
      FN_WR_RELAYS: begin
        chk_err   = !range_ok(RELAY_MIN, RELAY_MAX, f_arg, f_cnt, WR_RELAY_LIM)
                 || (f_bc != relay_bytes(f_cnt))
                 || (f_plen != LEN_WR_HEAD + f_bc);
        chk_items = f_cnt;
        chk_wr    = 1'b1;
      end
      FN_WR_WORDS: begin
        chk_err   = !range_ok(WORD_MIN, WORD_MAX, f_arg, f_cnt, WR_WORD_LIM)
                 || (f_bc != {f_cnt[14:0], 1'b0})
                 || (f_plen != LEN_WR_HEAD + f_bc);
        chk_items = f_cnt;
        chk_wr    = 1'b1;
        chk_word  = 1'b1;
      end
      default: begin
        chk_err  = 1'b1;
        chk_code = ERR_FUNC;
      end
    endcase
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= ST_RECV;
    end else begin
      case (state)
        ST_RECV: begin
          if (rx_done) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (chk_drop || chk_gw) begin
            state <= ST_RECV;
          end else if (chk_err) begin
            state <= ST_BUILD;
          end else begin
            state <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (idx == nitems) begin
            state <= ST_BUILD;
          end
        end
        ST_BUILD: state <= ST_EMIT;
        ST_EMIT: begin
          if (push_if.ready && (tx_idx == tx_total - 8'h01)) begin
            state <= ST_RECV;
          end
        end
        default: state <= ST_RECV;
      endcase
    end
  end

  // Captured request decode
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fn       <= '0;
      nitems   <= '0;
      is_write <= 1'b0;
      is_word  <= 1'b0;
      err      <= 1'b0;
      err_code <= '0;
    end else if (state == ST_CHECK) begin
      fn       <= f_fn;
      nitems   <= chk_items;
      is_write <= chk_wr;
      is_word  <= chk_word;
      err      <= chk_err;
      err_code <= chk_code;
    end
  end

  // Gateway hand-off pulse
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gw_fwd  <= 1'b0;
      gw_unit <= '0;
    end else begin
      gw_fwd <= (state == ST_CHECK) && !chk_drop && chk_gw;
      if (state == ST_CHECK) begin
        gw_unit <= f_unit;
      end
    end
  end

  // ==========================================================
  // Store port
  assign mem_req  = (state == ST_ACCESS) && (idx != nitems);
  assign mem_word = is_word;
  assign mem_we   = mem_req && is_write && mem_wr_ok;
  assign acc_fire = mem_req && mem_ack;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      idx       <= '0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else if (state == ST_CHECK) begin
      idx       <= '0;
      mem_addr  <= f_arg;
      mem_wdata <= item_data(f_fn, '0);
    end else if (acc_fire) begin
      idx       <= idx + 16'h0001;
      mem_addr  <= mem_addr + 16'h0001;
      mem_wdata <= item_data(fn, idx + 16'h0001);
    end
  end

  // ==========================================================
  // Frame buffer: request in, read data and header patch, response out
  logic [15:0] relay_n;
  logic [7:0]  rd_bytes;
  logic [7:0]  resp_len;
  logic [7:0]  rbyte_pos;
  logic [7:0]  rword_pos;

  assign relay_n   = relay_bytes(nitems);
  assign rd_bytes  = is_word ? {nitems[6:0], 1'b0} : relay_n[7:0];
  assign rbyte_pos = POS_RDATA + {3'h0, idx[7:3]};
  assign rword_pos = POS_RDATA + {idx[6:0], 1'b0};

  always_comb begin
    if (err) begin
      resp_len = LEN_ERR;
    end else if (!is_write && (fn != FN_LOOPBACK)) begin
      resp_len = rd_bytes + LEN_RD_HEAD;
    end else begin
      resp_len = LEN_ECHO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rx_fire && (rx_cnt < 17'(FRAME_DEPTH))) begin
      frame[rx_cnt[7:0]] <= rx_data;
    end else if (acc_fire && !is_write) begin
      if (is_word) begin
        frame[rword_pos]         <= mem_rdata[15:8];
        frame[rword_pos + 8'h01] <= mem_rdata[7:0];
      end else if (idx[2:0] == 3'h0) begin
        frame[rbyte_pos] <= {7'h00, mem_rdata[0]};
      end else begin
        frame[rbyte_pos] <= frame[rbyte_pos]
                          | ({7'h00, mem_rdata[0]} << idx[2:0]);
      end
    end else if (state == ST_BUILD) begin
      // Id, protocol and unit bytes stay as received
      frame[POS_LEN_HI] <= 8'h00;
      frame[POS_LEN_LO] <= resp_len;
      if (err) begin
        frame[POS_FN]     <= fn | EXC_FLAG;
        frame[POS_ARG_HI] <= err_code;
      end else if (!is_write && (fn != FN_LOOPBACK)) begin
        frame[POS_ARG_HI] <= rd_bytes;
      end
    end
  end

  // ==========================================================
  // Response emit into FIFO
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_idx   <= '0;
      tx_total <= '0;
    end else if (state == ST_BUILD) begin
      tx_idx   <= '0;
      tx_total <= LEN_BASE + resp_len;
    end else if ((state == ST_EMIT) && push_if.ready) begin
      tx_idx <= tx_idx + 8'h01;
    end
  end

  assign push_if.valid = (state == ST_EMIT);
  assign push_if.data  = frame[tx_idx];
  assign push_if.last  = (tx_idx == tx_total - 8'h01);
  assign tx_data       = pop_if.data;
  assign tx_last       = pop_if.last;
  assign tx_valid      = pop_if.valid;
  assign pop_if.ready  = tx_ready;

  mbs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr       (push_if.snk),
    .rd       (pop_if.src)
  );

  // ==========================================================
  // Idle watchdog: counts from the last request byte
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      idle_cnt   <= '0;
      conn_close <= 1'b0;
    end else begin
      conn_close <= 1'b0;
      if (!conn_open || rx_fire) begin
        idle_cnt <= '0;
      end else if (idle_cnt == 32'(IDLE_CYC - 1)) begin
        idle_cnt   <= '0;
        conn_close <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 32'h0000_0001;
      end
    end
  end

endmodule : mbs_server

/* sim/mbs_store.sv */
// Behavioural relay and word store on the far side of the server
`timescale 1ns/1ps
module mbs_store #(
  parameter logic [15:0] RO_WORD = 16'h0007
) (
  // Clock and pacing
  input wire logic         core_clk,
  input wire logic         slow,
  // Store port
  input wire logic         mem_req,
  input wire logic         mem_word,
  input wire logic         mem_we,
  input wire logic [15:0]  mem_addr,
  input wire logic [15:0]  mem_wdata,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack,
  output logic             mem_wr_ok
);
  // ====
  // Unwritten words read back their own number
  logic [15:0] wmem [int];
  logic        rmem [int];
  logic [15:0] val;
  logic        ph = 1'b0;
  always @(posedge core_clk) ph <= ~ph;
  assign mem_ack = mem_req && (!slow || ph);
  // One read-only word; all-ones lies outside every setting range
  assign mem_wr_ok = !mem_word || (mem_addr != RO_WORD && mem_wdata != 16'hFFFF);
  always @* begin
    if (mem_word) val = wmem.exists(mem_addr) ? wmem[mem_addr] : mem_addr;
    else val = {15'h0000, rmem.exists(mem_addr) && rmem[mem_addr]};
  end
  // Idle port shows the inverse so a held value cannot pass
  assign mem_rdata = mem_req ? val : ~val;
  always @(posedge core_clk) begin
    if (mem_req && mem_ack && mem_we) begin
      if (mem_word) wmem[mem_addr] = mem_wdata;
      else rmem[mem_addr] = mem_wdata[0];
    end
  end
endmodule : mbs_store

/* sim/mbs_server_sva.sv */
// Port-level assertions for the Modbus/TCP register server
`timescale 1ns/1ps
module mbs_server_sva
  import mbs_pkg::*;
#(
  parameter int IDLE_CYC = 50
) (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst_b,
  // Connection and streams
  input wire logic         conn_open,
  input wire logic         conn_close,
  input wire logic [7:0]   rx_data,
  input wire logic         rx_valid,
  input wire logic         rx_ready,
  input wire logic [7:0]   tx_data,
  input wire logic         tx_last,
  input wire logic         tx_valid,
  input wire logic         tx_ready,
  // Gateway and store
  input wire logic         gw_fwd,
  input wire logic [7:0]   gw_unit,
  input wire logic         mem_req,
  input wire logic         mem_word,
  input wire logic         mem_we,
  input wire logic [15:0]  mem_addr,
  input wire logic [15:0]  mem_wdata,
  input wire logic [15:0]  mem_rdata,
  input wire logic         mem_ack,
  input wire logic         mem_wr_ok
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ====
  // Idle span, cleared by any taken byte
  int idle_n;
  always_ff @(posedge core_clk) begin
    if (!rst_b || !conn_open || conn_close || (rx_valid && rx_ready)) idle_n <= 0;
    else idle_n <= idle_n + 1;
  end
  sequence s_pending; mem_req && !mem_ack; endsequence
  sequence s_stalled; tx_valid && !tx_ready; endsequence
  chk_we_gated: assert property (mem_we |-> mem_req && mem_wr_ok)
    else $error("Store write without grant");
  chk_req_holds: assert property (s_pending |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("Store request dropped or changed before ack");
  chk_access_blocks: assert property (mem_req |-> !rx_ready)
    else $error("Request bytes taken during store access");
  chk_close_pulse: assert property (conn_close |=> !conn_close)
    else $error("Close longer than one cycle");
  chk_close_late: assert property (conn_close |-> idle_n >= IDLE_CYC - 2)
    else $error("Close before idle span ran out");
  chk_gw_range: assert property (gw_fwd |-> gw_unit >= UNIT_GW_MIN && gw_unit <= UNIT_GW_MAX)
    else $error("Gateway unit out of range");
  chk_gw_quiet: assert property (gw_fwd |-> !mem_req [*3])
    else $error("Gateway request touched the local store");
  chk_tx_stands: assert property (s_stalled |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("Response byte changed while stalled");
endmodule : mbs_server_sva
bind mbs_server mbs_server_sva #(.IDLE_CYC(IDLE_CYC)) chk_u (.core_clk, .rst_b, .conn_open,
  .conn_close, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_last, .tx_valid, .tx_ready, .gw_fwd,
  .gw_unit, .mem_req, .mem_word, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .mem_wr_ok);

/* sim/mbs_server_bench.sv */
// Self-checking bench for the Modbus/TCP register server
`timescale 1ns/1ps
module mbs_server_bench;
  import mbs_pkg::*;
  localparam int IDLE = 400;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        conn_open = 1'b0;
  logic        rx_valid = 1'b0;
  logic        tx_ready = 1'b1;
  logic        slow = 1'b0;
  logic        stall = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic [7:0]  gw_seen = 8'h00;
  logic [15:0] tid = 16'h1230;
  logic [15:0] proto = 16'h0000;
  logic        conn_close, rx_ready, tx_last, tx_valid, gw_fwd, mem_req, mem_word, mem_we;
  logic        mem_ack, mem_wr_ok;
  logic [7:0]  tx_data, gw_unit;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  int          bad_count = 0;
  int          n_checks = 0;
  int          closes = 0;
  always #50 core_clk = ~core_clk;
  mbs_server #(.IDLE_CYC(IDLE)) dut_u (.core_clk, .rst_b, .conn_open, .conn_close, .rx_data,
    .rx_valid, .rx_ready, .tx_data, .tx_last, .tx_valid, .tx_ready, .gw_fwd, .gw_unit, .mem_req,
    .mem_word, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .mem_wr_ok);
  mbs_store store_u (.core_clk, .slow, .mem_req, .mem_word, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .mem_wr_ok);
  always @(posedge core_clk) begin
    if (gw_fwd) gw_seen <= gw_unit;
    if (conn_close) closes <= closes + 1;
  end
  // ====
  task automatic tick; @(posedge core_clk); #1; endtask : tick
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // One transaction: request of np bytes, expected PDU of ne bytes
  task automatic run(input logic [7:0] unit, input int np, input logic [95:0] p,
                     input int ne, input logic [95:0] e);
    logic [7:0]  q [$];
    logic [7:0]  x [$];
    logic [8:0]  got [$];
    logic [15:0] len;
    int          k;
    tid = tid + 16'h0101;
    len = 16'(np + 1);
    q = {tid[15:8], tid[7:0], proto[15:8], proto[7:0],
         len[15:8], len[7:0], unit};
    for (k = np - 1; k >= 0; k--) q.push_back(p[8*k +: 8]);
    if (ne > 0) x = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(ne + 1), UNIT_LOCAL};
    for (k = ne - 1; k >= 0; k--) x.push_back(e[8*k +: 8]);
    foreach (q[i]) begin
      rx_data = q[i];
      rx_valid = 1'b1;
      for (k = 0; k < 300 && !rx_ready; k++) tick();
      tick();
    end
    rx_valid = 1'b0;
    for (k = 0; k < 200 && !(got.size() > 0 && got[$][8]); k++) begin
      tx_ready = !(stall && k[0]);
      if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
      tick();
    end
    tx_ready = 1'b1;
    chk("resp_size", 16'(got.size()), 16'(x.size()));
    foreach (x[i]) begin
      if (i < got.size()) chk("resp_byte", {7'h00, got[i]}, {7'h00, (i == x.size() - 1), x[i]});
    end
  endtask : run
  task automatic echo(input int n, input logic [95:0] p); run(8'h01, n, p, n, p); endtask : echo
  task automatic t_word;
    echo(5, 40'h06_0005_1234);
    echo(5, 40'h06_0005_FFFF);
    echo(5, 40'h06_0007_ABCD);
    run(8'h01, 10, 80'h10_0014_0002_04_1111_2222, 5, 40'h10_0014_0002);
    run(8'h01, 5, 40'h03_0005_0003, 8, 64'h03_06_1234_0006_0007);
    run(8'h01, 5, 40'h03_0014_0002, 6, 48'h03_04_1111_2222);
  endtask : t_word
  task automatic t_relay;
    logic [111:0] adr = 112'h0FA3_0FA8_0FA3_0FA8_0FA1_0FA9_0FAB;
    logic [111:0] val = 112'hFF00_FF00_0000_1234_FF00_FF00_FF00;
    slow = 1'b1;
    stall = 1'b1;
    for (int i = 6; i >= 0; i--) echo(5, {8'h05, adr[16*i +: 16], val[16*i +: 16]});
    run(8'h01, 5, 40'h01_0FA1_000A, 4, 32'h01_02_81_01);
    run(8'h01, 8, 64'h0F_0FB0_000A_02_A5FF, 5, 40'h0F_0FB0_000A);
    run(8'h01, 5, 40'h01_0FB0_0010, 4, 32'h01_02_A5_03);
    slow = 1'b0;
    stall = 1'b0;
  endtask : t_relay
  task automatic t_error;
    echo(5, 40'h08_0000_BEEF);
    run(8'h01, 5, 40'h02_0000_0001, 2, 16'h8201);
    run(8'h01, 5, 40'h03_0000_0001, 2, 16'h8302);
    run(8'h01, 5, 40'h03_0001_0065, 2, 16'h8302);
    run(8'h01, 5, 40'h08_0001_BEEF, 2, 16'h8802);
  endtask : t_error
  task automatic t_gateway;
    run(8'h05, 5, 40'h03_0001_0001, 0, 0);
    chk("gw_unit", {8'h00, gw_seen}, 16'h0005);
    run(8'h64, 5, 40'h03_0001_0001, 0, 0);
    chk("gw_unit_keep", {8'h00, gw_seen}, 16'h0005);
    proto = 16'h0001;
    run(8'h01, 5, 40'h03_0001_0001, 0, 0);
    proto = 16'h0000;
  endtask : t_gateway
  task automatic t_idle;
    int c0;
    echo(5, 40'h08_0000_0000);
    c0 = closes;
    repeat (IDLE - 40) tick();
    chk("early_close", 16'(closes - c0), 16'h0000);
    repeat (60) tick();
    chk("idle_close", 16'(closes - c0), 16'h0001);
  endtask : t_idle
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    conn_open = 1'b1;
    t_word();
    t_relay();
    t_error();
    t_gateway();
    t_idle();
    end_of_test();
  end
  initial begin
    #(100 * 20000);
    bad_count++;
    end_of_test();
  end
endmodule : mbs_server_bench
